// ===== src/hisu_chan.sv
// One channel's status flags, mask, transfer mode and receive counting.
`timescale 1ns/1ps
`include "hisu_params.svh"
module hisu_chan
  import hisu_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Host writes and read-clears.
  input wire logic mask_we,
  input wire logic tx_byte_count_high_we,
  input wire logic channel_config_two_we,
  input wire logic [7:0] wdata,
  input wire logic rd_primary,
  input wire logic rd_extended,
  // Events and error actions.
  input wire hisu_ev_type ev,
  input wire hisu_resp_type resp,
  input wire logic xmr_ev,
  // State.
  output logic [7:0] primary_q,
  output logic [7:0] extended_q,
  output logic [7:0] mask_q,
  output logic dma_q,
  output logic [3:0] rx_frame_status_q,
  output logic vars_hold
);
  logic rie_q;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [7:0] pset;
  logic [7:0] eset;
  // Bytes counted in the pool; a pool-full hit restarts counting.
  wire pool_hit = ev.rx_byte && (cnt_q == `HISU_POOL - 7'h01);
  assign cnt_d = (ev.rx_end || pool_hit) ? 7'h00 : (ev.rx_byte ? cnt_q + 7'h01 : cnt_q);
  // Sources for each register.
  always_comb
  begin
    pset = 8'h00;
    eset = 8'h00;
    pset[`HISU_P_RPF] = !dma_q && pool_hit && !ev.rx_end;
    pset[`HISU_P_RME] = (dma_q ? ev.dma_done : ev.rx_end) || resp.set_rme;
    pset[`HISU_P_PCE] = resp.set_pce;
    pset[`HISU_P_XPR] = ev.tx_pool_empty || ev.tx_reset;
    eset[`HISU_E_XDU] = ev.tx_empty_no_eom;
    eset[`HISU_E_RFO] = ev.rx_buf_full && (ev.rx_start_addr_ok || ev.rx_start_flag2);
    eset[`HISU_E_RFS] = rie_q && (ev.rx_start_addr_ok || ev.rx_start_flag2);
    eset[`HISU_E_XMR] = xmr_ev;
  end
  assign vars_hold = resp.keep_vars;
  // Read clears, but a same-cycle event wins. Status is written in the same cycle the flag shows.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      primary_q <= 8'h00;
      extended_q <= 8'h00;
      mask_q <= `HISU_MASK_RST;
      dma_q <= 1'b0;
      rie_q <= 1'b0;
      cnt_q <= 7'h00;
      rx_frame_status_q <= `HISU_RS_OK;
    end
    else
    begin
      primary_q <= (rd_primary ? 8'h00 : primary_q) | pset;
      extended_q <= (rd_extended ? 8'h00 : extended_q) | eset;
      if (mask_we)
        mask_q <= wdata;
      if (tx_byte_count_high_we)
        dma_q <= wdata[`HISU_DMA_BIT];
      if (channel_config_two_we)
        rie_q <= wdata[`HISU_RIE_BIT];
      cnt_q <= cnt_d;
      if (resp.set_status)
        rx_frame_status_q <= resp.status;
      else if (ev.rx_start_addr_ok || ev.rx_start_flag2)
        rx_frame_status_q <= `HISU_RS_OK;
    end
  end
endmodule

// ===== src/hisu_err_map.sv
// Maps a received frame error to its response, flags and status.
`timescale 1ns/1ps
`include "hisu_params.svh"
module hisu_err_map
  import hisu_pkg::*;
(
  // Reported frame.
  input wire hisu_frame_type_rep_type frame,
  // Resulting action.
  output hisu_resp_type resp
);
  wire is_i = frame.valid && (frame.ftype == HISU_FR_I);
  wire is_s = frame.valid && (frame.ftype == HISU_FR_S);
  // Table of actions; supervisory damage is dropped, with a protocol error for a wrong number or info field.
  assign resp.send_s_resp = is_i && (frame.err == HISU_ER_NS);
  assign resp.set_rme = is_i && (frame.err == HISU_ER_CRC || frame.err == HISU_ER_ABORT);
  assign resp.set_pce = (is_i && frame.err == HISU_ER_NR) ||
    (is_s && (frame.err == HISU_ER_NR || frame.err == HISU_ER_IFIELD));
  assign resp.set_status = resp.set_rme;
  assign resp.status = (frame.err == HISU_ER_CRC) ? `HISU_RS_CRC : `HISU_RS_ABT;
  // Any erroneous frame freezes the station sequence variables.
  assign resp.keep_vars = frame.valid && (frame.err != HISU_ER_NONE);
endmodule

// ===== src/hisu_params.svh
// Constants of the dual-channel interrupt and error-status unit.
`ifndef HISU_PARAMS_SVH
`define HISU_PARAMS_SVH
// Primary status bit positions.
`define HISU_P_RME 7
`define HISU_P_RPF 6
`define HISU_P_XPR 5
`define HISU_P_PCE 4
`define HISU_P_RSV 3
`define HISU_P_ICA 2
`define HISU_P_EXA 1
`define HISU_P_EXB 0
// Extended status bit positions.
`define HISU_E_XDU 7
`define HISU_E_RFO 6
`define HISU_E_RFS 5
`define HISU_E_XMR 4
`define HISU_E_SPA 3
`define HISU_E_SPB 2
// Transfer-select bit in the high byte-count register.
`define HISU_DMA_BIT 7
// Frame-start enable bit in the second configuration register.
`define HISU_RIE_BIT 0
// Receive buffer pool size in bytes.
`define HISU_POOL 7'h20
// Receive status codes.
`define HISU_RS_OK 4'h0
`define HISU_RS_CRC 4'h2
`define HISU_RS_ABT 4'h1
// Reset values.
`define HISU_MASK_RST 8'h00
`define HISU_BYTE_RST 8'h00
`endif

// ===== src/hisu_pkg.sv
// Types shared by the interrupt and error-status unit.
package hisu_pkg;
  typedef enum logic [1:0] {HISU_FR_I, HISU_FR_S, HISU_FR_U} hisu_frame_type;
  typedef enum logic [2:0] {HISU_ER_NONE, HISU_ER_CRC, HISU_ER_ABORT, HISU_ER_NS, HISU_ER_NR, HISU_ER_IFIELD}
    hisu_err_type;
  typedef struct packed {
    logic valid;
    hisu_frame_type ftype;
    hisu_err_type err;
  } hisu_frame_type_rep_type;
  typedef struct packed {
    logic send_s_resp;
    logic set_rme;
    logic set_pce;
    logic set_status;
    logic [3:0] status;
    logic keep_vars;
  } hisu_resp_type;
  typedef struct packed {
    logic rx_byte;
    logic rx_end;
    logic rx_start_addr_ok;
    logic rx_start_flag2;
    logic rx_buf_full;
    logic dma_done;
    logic tx_pool_empty;
    logic tx_reset;
    logic tx_empty_no_eom;
  } hisu_ev_type;
endpackage

// ===== src/hisu_top.sv
// Top of the dual-channel interrupt and error-status unit.
// How it works
// - I-frame with checksum error or abort: no reply, message-end flag, status recorded.
// - Bad send number answers supervisory frame; bad receive number flags protocol error.
// - Bad supervisory frames dropped; wrong number or info field flags protocol error.
// - Erroneous frames never change the station send or receive variables.
// - Host talks through directly addressed eight-bit registers.
// - Each channel has its own independent identical register file.
// - Reset selects interrupt transfer; byte-count-high select bit chooses DMA.
// - Transfer mode is kept separately per channel.
// - One interrupt output; cause found by reading status registers.
// - Primary register shows four indications (bits 7..4), extended register six.
// - Channel B primary bits 2..0 point at A primary, A extended, B extended.
// - Channel B primary bits 7..4 carry channel B's own indications; bit 3 reads zero.
// - Interrupt stays low until all sources cleared by reading their registers.
// - Writing all-ones mask releases the line; restoring mask re-asserts it.
// - Each primary indication is blocked by its own mask bit.
// - Pool-full flag after 32 bytes of unfinished message, interrupt mode only.
// - Interrupt mode: message-end after checksum and closing flag arrive.
// - DMA mode: message-end after DMA has read the whole message, or at once for an I-frame checksum error or abort.
// - Frame-overflow when buffer is full and a new frame starts.
// - Frame-start flag needs its enable; after address match or two bytes.
// - Control byte, first address byte, status valid when frame-start is raised.
// - Transmit pool-ready when a 32-byte pool is empty, also after reset.
// - Underrun when transmit buffer drains without end of message.
`timescale 1ns/1ps
`include "hisu_params.svh"
module hisu_top
  import hisu_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Host register port, channel select 0 is A, 1 is B.
  input wire logic host_chan,
  input wire logic host_rd_primary,
  input wire logic host_rd_extended,
  input wire logic host_wr_mask,
  input wire logic host_wr_tx_byte_count_high,
  input wire logic host_wr_channel_config_two,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rx_control_byte,
  input wire logic [7:0] host_rx_address_low_one,
  output logic [7:0] host_rdata,
  // Per-channel frame reports and events.
  input wire hisu_frame_type_rep_type frame_a,
  input wire hisu_frame_type_rep_type frame_b,
  input wire hisu_ev_type ev_a,
  input wire hisu_ev_type ev_b,
  input wire logic xmr_a,
  input wire logic xmr_b,
  // Actions toward the protocol engine.
  output logic send_s_resp_a,
  output logic send_s_resp_b,
  output logic vars_hold_a,
  output logic vars_hold_b,
  output logic dma_mode_a,
  output logic dma_mode_b,
  output logic [3:0] rx_frame_status_a,
  output logic [3:0] rx_frame_status_b,
  output logic [7:0] rx_control_byte,
  output logic [7:0] rx_address_low_one,
  // Shared interrupt request.
  output logic irq_n
);
  hisu_resp_type resp_a;
  hisu_resp_type resp_b;
  logic [7:0] pa;
  logic [7:0] pb;
  logic [7:0] ea;
  logic [7:0] eb;
  logic [7:0] ma;
  logic [7:0] mb;
  logic hold_a;
  logic hold_b;
  logic dma_a;
  logic dma_b;
  logic [3:0] st_a;
  logic [3:0] st_b;
  logic send_a_q;
  logic send_b_q;
  logic [7:0] rdata_q;
  logic irq_n_q;
  logic [7:0] rx_control_byte_q;
  logic [7:0] ral_q;

  // ****************************************
  // Error mapping per channel
  // ****************************************
  hisu_err_map u_map_a (.frame(frame_a), .resp(resp_a));
  hisu_err_map u_map_b (.frame(frame_b), .resp(resp_b));

  // ****************************************
  // Two independent channel files
  // ****************************************
  // Decoded strobes; channel select steers every access.
  wire sel_a = !host_chan;
  wire sel_b = host_chan;
  hisu_chan u_chan_a (
    .core_clk(core_clk), .rst(rst),
    .mask_we(host_wr_mask && sel_a),
    .tx_byte_count_high_we(host_wr_tx_byte_count_high && sel_a),
    .channel_config_two_we(host_wr_channel_config_two && sel_a),
    .wdata(host_wdata),
    .rd_primary(host_rd_primary && sel_a),
    .rd_extended(host_rd_extended && sel_a),
    .ev(ev_a), .resp(resp_a), .xmr_ev(xmr_a),
    .primary_q(pa), .extended_q(ea), .mask_q(ma), .dma_q(dma_a),
    .rx_frame_status_q(st_a), .vars_hold(hold_a)
  );
  hisu_chan u_chan_b (
    .core_clk(core_clk), .rst(rst),
    .mask_we(host_wr_mask && sel_b),
    .tx_byte_count_high_we(host_wr_tx_byte_count_high && sel_b),
    .channel_config_two_we(host_wr_channel_config_two && sel_b),
    .wdata(host_wdata),
    .rd_primary(host_rd_primary && sel_b),
    .rd_extended(host_rd_extended && sel_b),
    .ev(ev_b), .resp(resp_b), .xmr_ev(xmr_b),
    .primary_q(pb), .extended_q(eb), .mask_q(mb), .dma_q(dma_b),
    .rx_frame_status_q(st_b), .vars_hold(hold_b)
  );

  // ****************************************
  // Pointer bits and read view
  // ****************************************
  // Channel A's primary word shows its four indications (bits 7..4); B adds pointers.
  wire [7:0] src_mask = 8'hF0;
  wire [7:0] pa_view = pa & src_mask;
  wire [7:0] ea_view = ea & 8'hFC;
  wire [7:0] eb_view = eb & 8'hFC;
  wire chan_a_primary_pending = |(pa_view & ~ma);
  wire chan_a_extended_pending = |ea_view;
  wire chan_b_extended_pending = |eb_view;
  wire [7:0] pb_view = {pb[7:3] & 5'b11110, chan_a_primary_pending, chan_a_extended_pending, chan_b_extended_pending};
  // Selected read data; ordering for the service routine is the host's job.
  wire [7:0] rd_sel = host_rd_extended ? (sel_b ? eb_view : ea_view)
                                       : (sel_b ? pb_view : pa_view);

  // ****************************************
  // Interrupt request
  // ****************************************
  // A masked indication never drives the line; the all-ones mask releases
  // it and restoring the mask brings it back while sources remain.
  wire b_pend = |(pb & src_mask & ~mb);
  wire a_pend = |(pa_view & ~ma);
  // The pointer bits of channel B's mask hold back the extended sources as well,
  // otherwise an all-ones mask could not release the line while an extended flag waits.
  wire exa_pend = chan_a_extended_pending && !mb[`HISU_P_EXA];
  wire exb_pend = chan_b_extended_pending && !mb[`HISU_P_EXB];
  wire any_pend = a_pend || b_pend || exa_pend || exb_pend;
  // Registered so the output is glitch-free; costs one cycle of latency.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_n_q <= 1'b1;
      rdata_q <= 8'h00;
      send_a_q <= 1'b0;
      send_b_q <= 1'b0;
      rx_control_byte_q <= `HISU_BYTE_RST;
      ral_q <= `HISU_BYTE_RST;
    end
    else
    begin
      irq_n_q <= !any_pend;
      if (host_rd_primary || host_rd_extended)
        rdata_q <= rd_sel;
      send_a_q <= resp_a.send_s_resp;
      send_b_q <= resp_b.send_s_resp;
      if (ev_a.rx_start_addr_ok || ev_a.rx_start_flag2 || ev_b.rx_start_addr_ok || ev_b.rx_start_flag2)
      begin
        rx_control_byte_q <= host_rx_control_byte;
        ral_q <= host_rx_address_low_one;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign irq_n = irq_n_q;
  assign host_rdata = rdata_q;
  assign send_s_resp_a = send_a_q;
  assign send_s_resp_b = send_b_q;
  assign vars_hold_a = hold_a;
  assign vars_hold_b = hold_b;
  assign dma_mode_a = dma_a;
  assign dma_mode_b = dma_b;
  assign rx_frame_status_a = st_a;
  assign rx_frame_status_b = st_b;
  assign rx_control_byte = rx_control_byte_q;
  assign rx_address_low_one = ral_q;
endmodule

// ===== test/hisu_host_model.sv
// Host processor model that reads and writes the unit's registers.
`timescale 1ns/1ps
module hisu_host_model
(
  // Clock.
  input wire logic core_clk,
  // Strobes and data toward the unit.
  output logic host_chan,
  output logic host_rd_primary,
  output logic host_rd_extended,
  output logic host_wr_mask,
  output logic host_wr_tx_byte_count_high,
  output logic host_wr_channel_config_two,
  output logic [7:0] host_wdata,
  // Read data.
  input wire logic [7:0] host_rdata
);
  // ***
  // Bus cycles
  // ***
  logic [7:0] msk [2];
  // The bus idles from time zero.
  initial
  begin
    {host_chan, host_rd_primary, host_rd_extended, host_wr_mask, host_wr_tx_byte_count_high} = '0;
    {host_wr_channel_config_two, host_wdata} = '0;
    msk = '{8'h00, 8'h00};
  end
  // Read strobe for one cycle; registered data is taken a cycle later.
  task automatic rd(input logic c, input logic e, output logic [7:0] d);
    @(negedge core_clk);
    host_chan = c;
    host_rd_primary = !e;
    host_rd_extended = e;
    @(negedge core_clk);
    {host_rd_primary, host_rd_extended} = '0;
    @(negedge core_clk);
    d = host_rdata;
  endtask
  // Write strobe; kind 0 is mask, 1 byte count high, 2 config two.
  task automatic wr(input int k, input logic c, input logic [7:0] v);
    @(negedge core_clk);
    host_chan = c;
    host_wdata = v;
    {host_wr_mask, host_wr_tx_byte_count_high, host_wr_channel_config_two} = {k == 0, k == 1, k == 2};
    if (k == 0)
      msk[c] = v;
    @(negedge core_clk);
    {host_wr_mask, host_wr_tx_byte_count_high, host_wr_channel_config_two} = '0;
  endtask
  // Service: channel B primary first, then what it points at, then a mask toggle.
  task automatic service();
    logic [7:0] s, d, a, b;
    a = msk[0];
    b = msk[1];
    rd(1'b1, 1'b0, s);
    if (s[2])
      rd(1'b0, 1'b0, d);
    if (s[1])
      rd(1'b0, 1'b1, d);
    if (s[0])
      rd(1'b1, 1'b1, d);
    wr(0, 1'b0, 8'hFF);
    wr(0, 1'b1, 8'hFF);
    wr(0, 1'b0, a);
    wr(0, 1'b1, b);
  endtask
endmodule

// ===== test/hisu_top_asserts.sv
// Concurrent checks on the ports of the interrupt and error-status unit.
`timescale 1ns/1ps
module hisu_top_asserts
  import hisu_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Host strobes.
  input wire logic host_chan,
  input wire logic host_wr_mask,
  input wire logic host_wr_tx_byte_count_high,
  input wire logic [7:0] host_wdata,
  // Channel A inputs and outputs, channel B transfer mode, shared request.
  input wire hisu_frame_type_rep_type frame_a,
  input wire hisu_ev_type ev_a,
  input wire logic send_s_resp_a,
  input wire logic vars_hold_a,
  input wire logic dma_mode_a,
  input wire logic dma_mode_b,
  input wire logic [3:0] rx_frame_status_a,
  input wire logic irq_n
);
  // ***
  // Checks
  // ***
  logic [7:0] mask_a_q;
  logic i_fr;
  logic ns_err;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Frame decode shared by several checks.
  assign i_fr = frame_a.valid && frame_a.ftype == HISU_FR_I;
  assign ns_err = i_fr && frame_a.err == HISU_ER_NS;
  // Shadow of the channel A mask, needed to know when a flag may drive the request.
  always_ff @(posedge core_clk)
    if (rst)
      mask_a_q <= 8'h00;
    else if (host_wr_mask && !host_chan)
      mask_a_q <= host_wdata;
  a_ns_resp: assert property (ns_err |=> send_s_resp_a)
    else $error("S response missing");
  a_no_resp: assert property (!ns_err |=> !send_s_resp_a)
    else $error("Unexpected S response");
  a_hold_vars: assert property (frame_a.valid && frame_a.err != HISU_ER_NONE |-> vars_hold_a)
    else $error("Station variables not held");
  a_crc_status: assert property (i_fr && frame_a.err == HISU_ER_CRC |=> rx_frame_status_a == 4'h2)
    else $error("Checksum status wrong");
  a_abort_status: assert property (i_fr && frame_a.err == HISU_ER_ABORT |=> rx_frame_status_a == 4'h1)
    else $error("Abort status wrong");
  a_reset_state: assert property (disable iff (1'b0) rst |=> irq_n && !dma_mode_a && !dma_mode_b)
    else $error("Reset state wrong");
  a_dma_select: assert property (host_wr_tx_byte_count_high && !host_chan |=>
    dma_mode_a == $past(host_wdata[7]) && $stable(dma_mode_b)) else $error("Transfer mode wrong");
  a_msg_irq: assert property (ev_a.rx_end && !dma_mode_a && !mask_a_q[7] |-> ##2 !irq_n)
    else $error("Request not raised");
endmodule
bind hisu_top hisu_top_asserts i_hisu_top_asserts (.core_clk, .rst, .host_chan, .host_wr_mask,
  .host_wr_tx_byte_count_high, .host_wdata, .frame_a, .ev_a, .send_s_resp_a, .vars_hold_a, .dma_mode_a,
  .dma_mode_b, .rx_frame_status_a, .irq_n);

// ===== test/test_hisu_top.sv
// Self-checking testbench of the interrupt and error-status unit.
`timescale 1ns/1ps
module test_hisu_top
  import hisu_pkg::*;
;
  // ***
  // Bench
  // ***
  logic core_clk, rst, host_chan, host_rd_primary, host_rd_extended, host_wr_mask, xmr_a, xmr_b, irq_n;
  logic host_wr_tx_byte_count_high, host_wr_channel_config_two, send_s_resp_a, send_s_resp_b;
  logic vars_hold_a, vars_hold_b, dma_mode_a, dma_mode_b;
  logic [7:0] host_wdata, host_rx_control_byte, host_rx_address_low_one, host_rdata;
  logic [7:0] rx_control_byte, rx_address_low_one;
  logic [3:0] rx_frame_status_a, rx_frame_status_b;
  hisu_frame_type_rep_type frame_a, frame_b;
  hisu_ev_type ev_a, ev_b;
  int n_errors, checks;
  // Event bit positions follow the field order of the event struct.
  localparam int EV_END = 7, EV_ADDR = 6, EV_FLAG2 = 5, EV_DMA = 3;
  hisu_top i_hisu_top (.core_clk, .rst, .host_chan, .host_rd_primary, .host_rd_extended, .host_wr_mask,
    .host_wr_tx_byte_count_high, .host_wr_channel_config_two, .host_wdata, .host_rx_control_byte,
    .host_rx_address_low_one, .host_rdata, .frame_a, .frame_b, .ev_a, .ev_b, .xmr_a, .xmr_b, .send_s_resp_a,
    .send_s_resp_b, .vars_hold_a, .vars_hold_b, .dma_mode_a, .dma_mode_b, .rx_frame_status_a,
    .rx_frame_status_b, .rx_control_byte, .rx_address_low_one, .irq_n);
  hisu_host_model i_hisu_host_model (.core_clk, .host_chan, .host_rd_primary, .host_rd_extended,
    .host_wr_mask, .host_wr_tx_byte_count_high, .host_wr_channel_config_two, .host_wdata, .host_rdata);
  // Free-running clock.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("%0d checks, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One-cycle event on channel A (b low) or B (b high).
  task automatic pulse(input logic b, input int i);
    @(negedge core_clk);
    if (b)
      ev_b = hisu_ev_type'(9'h001 << i);
    else
      ev_a = hisu_ev_type'(9'h001 << i);
    @(negedge core_clk);
    {ev_a, ev_b} = '0;
  endtask
  task automatic bytes(input int n);
    @(negedge core_clk);
    ev_a.rx_byte = 1'b1;
    repeat (n) @(negedge core_clk);
    ev_a.rx_byte = 1'b0;
  endtask
  task automatic rc(input logic c, input logic e, input logic [7:0] x, input string n);
    logic [7:0] d;
    i_hisu_host_model.rd(c, e, d);
    chk(n, d, x);
  endtask
  // Bounded wait for the request line; running out ends the run.
  task automatic wait_irq(input logic v);
    for (int i = 0; i < 8 && irq_n !== v; i++)
      @(negedge core_clk);
    chk("irq_n", irq_n, v);
    if (irq_n !== v)
      print_verdict();
  endtask
  task automatic t_walk();
    chk("dma_mode_a", dma_mode_a, 8'h00);
    pulse(0, EV_END);
    wait_irq(0);
    rc(1, 0, 8'h04, "pri_b");
    rc(0, 0, 8'h80, "pri_a");
    wait_irq(1);
    $display("walk test done");
  endtask
  // Every error pairing of the table; skipped pairs are not listed there.
  task automatic t_errors();
    for (int f = 0; f < 2; f++)
      for (int r = 1; r < 6; r++)
      begin
        if ((f == 0 && r == 5) || (f == 1 && r == 3))
          continue;
        @(negedge core_clk);
        frame_a = '{1'b1, hisu_frame_type'(f), hisu_err_type'(r)};
        #1;
        chk("vars_hold_a", vars_hold_a, 8'h01);
        @(negedge core_clk);
        frame_a = '0;
        chk("send_s_resp_a", send_s_resp_a, f == 0 && r == 3);
        if (f == 0 && r < 3)
          chk("status_a", rx_frame_status_a, r == 1 ? 8'h02 : 8'h01);
        rc(0, 0, (f == 0 && r < 3) ? 8'h80 : (r > 3 ? 8'h10 : 8'h00), "pri_a");
      end
    $display("error test done");
  endtask
  task automatic t_pool();
    bytes(31);
    rc(0, 0, 8'h00, "pri_a");
    bytes(1);
    rc(0, 0, 8'h40, "pri_a");
    i_hisu_host_model.wr(1, 1'b0, 8'h80);
    chk("dma_mode_a", dma_mode_a, 8'h01);
    chk("dma_mode_b", dma_mode_b, 8'h00);
    bytes(32);
    pulse(0, EV_END);
    rc(0, 0, 8'h00, "pri_a");
    pulse(0, EV_DMA);
    rc(0, 0, 8'h80, "pri_a");
    i_hisu_host_model.wr(1, 1'b0, 8'h00);
    $display("pool test done");
  endtask
  task automatic t_mask();
    pulse(1, EV_END);
    wait_irq(0);
    i_hisu_host_model.wr(0, 1'b1, 8'hFF);
    wait_irq(1);
    i_hisu_host_model.wr(0, 1'b1, 8'h00);
    wait_irq(0);
    i_hisu_host_model.wr(0, 1'b1, 8'h80);
    wait_irq(1);
    i_hisu_host_model.wr(0, 1'b1, 8'h00);
    wait_irq(0);
    i_hisu_host_model.service();
    wait_irq(1);
    $display("mask test done");
  endtask
  task automatic t_start();
    pulse(1, EV_ADDR);
    rc(1, 1, 8'h00, "ext_b");
    i_hisu_host_model.wr(2, 1'b1, 8'h01);
    host_rx_control_byte = 8'h5A;
    for (int i = EV_FLAG2; i <= EV_ADDR; i++)
    begin
      pulse(1, i);
      i_hisu_host_model.wr(0, 1'b1, 8'hFF);
      wait_irq(1);
      i_hisu_host_model.wr(0, 1'b1, 8'h00);
      wait_irq(0);
      chk("ctrl", rx_control_byte, 8'h5A);
      chk("addr", rx_address_low_one, 8'hC3);
      chk("status_b", rx_frame_status_b, 8'h00);
      rc(1, 0, 8'h01, "pri_b");
      rc(1, 1, 8'h20, "ext_b");
    end
    $display("start test done");
  endtask
  // Transmit events, overflow, repeat flag and channel B error actions.
  task automatic t_more();
    pulse(0, 2);
    rc(0, 0, 8'h20, "pri_a");
    pulse(0, 1);
    rc(0, 0, 8'h20, "pri_a");
    pulse(0, 0);
    rc(0, 1, 8'h80, "ext_a");
    @(negedge core_clk);
    ev_a = hisu_ev_type'(9'h050);
    @(negedge core_clk);
    ev_a = '0;
    rc(0, 1, 8'h40, "ext_a");
    @(negedge core_clk);
    xmr_b = 1'b1;
    @(negedge core_clk);
    xmr_b = 1'b0;
    rc(1, 1, 8'h10, "ext_b");
    @(negedge core_clk);
    frame_b = '{1'b1, HISU_FR_I, HISU_ER_NS};
    #1;
    chk("vars_hold_b", vars_hold_b, 8'h01);
    @(negedge core_clk);
    frame_b = '0;
    chk("send_s_resp_b", send_s_resp_b, 8'h01);
    $display("more test done");
  endtask
  // Main sequence; every scenario starts from an idle bus.
  initial
  begin
    {rst, n_errors, checks} = {1'b1, 32'd0, 32'd0};
    {frame_a, frame_b, ev_a, ev_b, xmr_a, xmr_b} = '0;
    host_rx_control_byte = 8'h00;
    host_rx_address_low_one = 8'hC3;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    t_walk();
    t_errors();
    t_pool();
    t_mask();
    t_start();
    t_more();
    print_verdict();
  end
endmodule
